// *** verilog/key_matrix_scanner.sv ***
// Function
// - transfer accepted only for control frame or key data read address
// - frame order: drive, zeros, outputs, zeros, select
// - select bits turn shared pins into outputs
// - drive bit sets idle level; low never pulses
// - output bits set general output levels
// - key bit 5*(r-1)+c, pressed is one
// - shared pins as outputs report zero keys
// - one scan lasts 288 oscillator periods
// - two agreeing scans needed, else rescan while a sense line is high, idle if none
// - request low 615 periods after scan start
// - scan timing unit is oscillator period
// - oscillator idle until key on high line
// - request released while enable high in transfer
// - after read, clear request and rescan
// - simultaneous presses set several bits
// - reset: no scan, outputs low, keys cleared
// - scan waits for frame; request high in reset
`default_nettype none
module key_matrix_scanner
   import key_scan_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIV_DEF
)
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic reset_n_pin_i,
   input wire logic chip_enable_i,
   input wire logic serial_shift_clock_i,
   input wire logic serial_in_i,
   input wire logic [NUM_COLS-1:0] sense_inputs_i,
   output logic [2:0] scan_drive_lines_o,
   output logic [2:0] shared_drive_output_pins_o,
   output logic general_outputs_o,
   output logic data_out_o,
   output logic data_out_oe_o
);
   typedef enum {ST_IDLE, ST_SCAN, ST_HOLD, ST_REQ} scan_st_t;

   // rows usable for scanning under the pin-sharing select
   function automatic logic [NUM_ROWS-1:0] row_mask(input logic [1:0] kp);
      logic [NUM_ROWS-1:0] m;
      m = 6'h3f;
      case (kp)
         2'b10: m = 6'h1f; // kp1 only: last pin is an output
         2'b01: m = 6'h0f;
         2'b11: m = 6'h07;
         default: m = 6'h3f;
      endcase
      return m;
   endfunction

   // ----------------------------------------------------------------
   // input synchronisers
   // ----------------------------------------------------------------
   logic [8:0] meta_r, sync_r;
   logic ce_d_r, cl_d_r;
   wire logic rst_pin_s = sync_r[0];
   wire logic ce_s = sync_r[1];
   wire logic cl_s = sync_r[2];
   wire logic di_s = sync_r[3];
   wire logic [NUM_COLS-1:0] sense_s = sync_r[8:4];
   wire logic dev_rst = srst_i || !rst_pin_s;

   // two flops per pin; all logic reads only the second
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i)
      begin
         meta_r <= 9'h000;
         sync_r <= 9'h000;
         ce_d_r <= 1'b0;
         cl_d_r <= 1'b0;
      end
      else if (clk_en_i)
      begin
         meta_r <= {sense_inputs_i, serial_in_i, serial_shift_clock_i,
                    chip_enable_i, reset_n_pin_i};
         sync_r <= meta_r;
         ce_d_r <= ce_s;
         cl_d_r <= cl_s;
      end
   end

   wire logic cl_rise = cl_s && !cl_d_r;
   wire logic ce_rise = ce_s && !ce_d_r;
   wire logic ce_fall = !ce_s && ce_d_r;

   // ----------------------------------------------------------------
   // serial port: address with enable low, payload with enable high
   // ----------------------------------------------------------------
   logic [ADDR_BITS-1:0] addr_r;
   logic [CTRL_BITS-1:0] frame_r;
   logic [4:0] bit_cnt_r;
   logic wr_act_r, rd_act_r;
   logic [NUM_ROWS-1:0] drive_lvl_r;
   logic [3:0] out_lvl_r;
   logic [1:0] kp_r;
   logic cfg_valid_r;
   logic read_done;

   // address shifts in lowest bit first while enable is low
   always_ff @(posedge core_clk_i)
   begin
      if (dev_rst)
      begin
         addr_r <= '0;
         wr_act_r <= 1'b0;
         rd_act_r <= 1'b0;
         frame_r <= '0;
         bit_cnt_r <= 5'h00;
      end
      else if (clk_en_i)
      begin
         if (!ce_s && cl_rise)
            addr_r <= {di_s, addr_r[ADDR_BITS-1:1]};
         if (ce_rise)
         begin
            wr_act_r <= (addr_r == DEV_ADDR);
            rd_act_r <= (addr_r == READ_ADDR);
            bit_cnt_r <= 5'h00;
         end
         else if (ce_fall)
         begin
            wr_act_r <= 1'b0;
            rd_act_r <= 1'b0;
         end
         else if (ce_s && cl_rise)
         begin
            if (wr_act_r)
               frame_r <= {di_s, frame_r[CTRL_BITS-1:1]};
            if (bit_cnt_r != 5'h1f)
               bit_cnt_r <= bit_cnt_r + 5'h01;
         end
      end
   end

   // a control frame takes effect when enable falls after 16 bits
   always_ff @(posedge core_clk_i)
   begin
      if (dev_rst)
      begin
         drive_lvl_r <= DRIVE_RST;
         out_lvl_r <= OUT_RST;
         kp_r <= KP_RST;
         cfg_valid_r <= 1'b0;
      end
      else if (clk_en_i && ce_fall && wr_act_r && bit_cnt_r == 5'(CTRL_BITS))
      begin
         drive_lvl_r <= frame_r[POS_DRIVE +: NUM_ROWS];
         out_lvl_r <= frame_r[POS_OUT +: 4];
         kp_r <= {frame_r[POS_KP1], frame_r[POS_KP2]};
         cfg_valid_r <= 1'b1;
      end
   end

   assign read_done = ce_fall && rd_act_r;

   // ----------------------------------------------------------------
   // scan engine, paced by the oscillator period
   // ----------------------------------------------------------------
   scan_st_t st_r;
   logic tick;
   logic [9:0] t_cnt_r;
   logic [5:0] slot_r;
   logic [2:0] row_r;
   logic pass_r;
   logic [KEY_BITS-1:0] scan_a_r, scan_b_r, keys_r;
   wire logic [NUM_ROWS-1:0] scan_rows = row_mask(kp_r);
   wire logic [NUM_ROWS-1:0] live_rows = scan_rows & drive_lvl_r;
   wire logic osc_run = (st_r == ST_SCAN) || (st_r == ST_HOLD);
   // the last row lands in scan_b_r on the same edge as the compare, so splice it in
   wire logic [NUM_COLS-1:0] row_smp = sense_s & {NUM_COLS{live_rows[row_r]}};
   wire logic [KEY_BITS-1:0] scan_b_fresh = {row_smp, scan_b_r[KEY_BITS-NUM_COLS-1:0]};
   wire logic slot_end = tick && (slot_r == 6'(ROW_SLOT_T - 1));
   wire logic scan_end = slot_end && (row_r == 3'(NUM_ROWS - 1));

   osc_tick #(.DIV(OSC_DIV)) u_osc (
      .core_clk_i(core_clk_i),
      .srst_i(dev_rst),
      .clk_en_i(clk_en_i),
      .run_i(osc_run),
      .tick_o(tick)
   );

   // row slots of 48 periods, six rows per scan, two scans per check
   always_ff @(posedge core_clk_i)
   begin
      if (dev_rst || !osc_run)
      begin
         slot_r <= 6'h00;
         row_r <= 3'h0;
      end
      else if (clk_en_i && tick && st_r == ST_SCAN)
      begin
         slot_r <= slot_end ? 6'h00 : slot_r + 6'h01;
         if (slot_end)
            row_r <= scan_end ? 3'h0 : row_r + 3'h1;
      end
   end

   // sense sampled at slot end; bit index 5*row+col
   always_ff @(posedge core_clk_i)
   begin
      if (dev_rst || st_r == ST_IDLE)
      begin
         scan_a_r <= '0;
         scan_b_r <= '0;
      end
      else if (clk_en_i && slot_end && st_r == ST_SCAN)
      begin
         for (int c = 0; c < NUM_COLS; c++)
         begin
            if (!pass_r)
               scan_a_r[row_r*NUM_COLS + c] <= sense_s[c] && live_rows[row_r];
            else
               scan_b_r[row_r*NUM_COLS + c] <= sense_s[c] && live_rows[row_r];
         end
      end
   end

   // main sequence: start, double scan, compare, hold, request, read
   always_ff @(posedge core_clk_i)
   begin
      if (dev_rst)
      begin
         st_r <= ST_IDLE;
         t_cnt_r <= 10'h000;
         pass_r <= 1'b0;
         keys_r <= '0;
      end
      else if (clk_en_i)
      begin
         case (st_r)
            ST_IDLE:
            begin
               t_cnt_r <= 10'h000;
               pass_r <= 1'b0;
               // drive lines idle at their levels, so a sense high is a key
               if (cfg_valid_r && (|sense_s) && (|live_rows))
                  st_r <= ST_SCAN;
            end
            ST_SCAN:
            begin
               if (tick)
                  t_cnt_r <= t_cnt_r + 10'h001;
               if (scan_end)
               begin
                  pass_r <= !pass_r;
                  if (pass_r)
                  begin
                     // compare uses the fresh sample of the last row
                     if (scan_a_r == scan_b_fresh && |scan_a_r)
                        st_r <= ST_HOLD;
                     else if (scan_a_r != scan_b_fresh && (|sense_s))
                        t_cnt_r <= 10'h000;
                     else
                        st_r <= ST_IDLE; // scans agreed on no keys, or no sense line high on the last row
                  end
               end
            end
            ST_HOLD:
            begin
               if (tick)
                  t_cnt_r <= t_cnt_r + 10'h001;
               if (tick && t_cnt_r == 10'(REQ_DELAY_T - 1))
               begin
                  keys_r <= scan_a_r;
                  st_r <= ST_REQ;
               end
            end
            ST_REQ:
            begin
               if (read_done)
               begin
                  t_cnt_r <= 10'h000;
                  pass_r <= 1'b0;
                  st_r <= ST_SCAN;
               end
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // pin outputs, all registered
   // ----------------------------------------------------------------
   logic [NUM_ROWS-1:0] drive_nxt;
   logic [2:0] shared_nxt;
   always_comb
   begin
      drive_nxt = drive_lvl_r;
      if (st_r == ST_SCAN)
      begin
         // only the row under scan pulses, and only if its level is high
         drive_nxt = '0;
         drive_nxt[row_r] = drive_lvl_r[row_r];
      end
      // shared pin order: drive 4 / out 4, drive 5 / out 3, drive 6 / out 2
      shared_nxt[0] = scan_rows[3] ? drive_nxt[3] : out_lvl_r[3];
      shared_nxt[1] = scan_rows[4] ? drive_nxt[4] : out_lvl_r[2];
      shared_nxt[2] = scan_rows[5] ? drive_nxt[5] : out_lvl_r[1];
   end

   always_ff @(posedge core_clk_i)
   begin
      if (dev_rst)
      begin
         scan_drive_lines_o <= 3'h0;
         shared_drive_output_pins_o <= 3'h0;
         general_outputs_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         scan_drive_lines_o <= drive_nxt[2:0];
         shared_drive_output_pins_o <= shared_nxt;
         general_outputs_o <= out_lvl_r[0];
      end
   end

   // open drain: enable pulls the line low, a pull-up gives high
   always_ff @(posedge core_clk_i)
   begin
      data_out_o <= 1'b0;
      if (dev_rst)
         data_out_oe_o <= 1'b0;
      else if (clk_en_i)
      begin
         if (rd_act_r && ce_s)
            data_out_oe_o <= (bit_cnt_r < 5'(KEY_BITS)) ? !keys_r[bit_cnt_r] : 1'b1;
         else if (ce_s)
            data_out_oe_o <= 1'b0;
         else
            data_out_oe_o <= (st_r == ST_REQ) && !read_done;
      end
   end
endmodule
`default_nettype wire

// *** verilog/key_scan_pkg.sv ***
`default_nettype none
package key_scan_pkg;
   // ----------------------------------------------------------------
   // serial port
   // ----------------------------------------------------------------
   localparam logic [7:0] DEV_ADDR = 8'h62;  // control frame address
   localparam logic [7:0] READ_ADDR = 8'h63; // key data read address
   localparam int ADDR_BITS = 8;
   localparam int CTRL_BITS = 16;
   // control frame bit positions, in order of arrival
   localparam int POS_DRIVE = 0;  // six drive level bits
   localparam int POS_OUT = 8;    // four output level bits
   localparam int POS_KP1 = 14;
   localparam int POS_KP2 = 15;
   // ----------------------------------------------------------------
   // matrix and scan timing, in oscillator periods
   // ----------------------------------------------------------------
   localparam int NUM_ROWS = 6;
   localparam int NUM_COLS = 5;
   localparam int KEY_BITS = NUM_ROWS * NUM_COLS;
   localparam int SCAN_PERIOD_T = 288;
   localparam int ROW_SLOT_T = SCAN_PERIOD_T / NUM_ROWS;
   localparam int REQ_DELAY_T = 615;
   localparam int OSC_DIV_DEF = 16; // core cycles per oscillator period
   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [5:0] DRIVE_RST = 6'h00;
   localparam logic [3:0] OUT_RST = 4'h0;
   localparam logic [1:0] KP_RST = 2'h0;
endpackage
`default_nettype wire

// *** verilog/osc_tick.sv ***
`default_nettype none
module osc_tick
   import key_scan_pkg::*;
#(
   parameter int DIV = OSC_DIV_DEF
)
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic run_i,
   output logic tick_o
);
   localparam int CW = $clog2(DIV + 1);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);
   logic [CW-1:0] cnt_r;

   // ----------------------------------------------------------------
   // oscillator model: stands still while not running
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_i)
   begin
      if (srst_i || !run_i)
      begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end
      else if (clk_en_i)
      begin
         tick_o <= (cnt_r == LAST);
         cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
      end
   end
endmodule
`default_nettype wire

// *** bench/key_scan_props.sv ***
`default_nettype none
module key_scan_props
   import key_scan_pkg::*;
#(
   parameter int OSC_DIV = OSC_DIV_DEF
)
(
   input wire logic core_clk_i,
   input wire logic srst_i,
   input wire logic clk_en_i,
   input wire logic reset_n_pin_i,
   input wire logic chip_enable_i,
   input wire logic serial_shift_clock_i,
   input wire logic serial_in_i,
   input wire logic [NUM_COLS-1:0] sense_inputs_i,
   input wire logic [2:0] scan_drive_lines_o,
   input wire logic [2:0] shared_drive_output_pins_o,
   input wire logic general_outputs_o,
   input wire logic data_out_o,
   input wire logic data_out_oe_o
);
   // ----------------------------------------
   // helper state
   // ----------------------------------------
   localparam int IDLE_LIM = 700 * OSC_DIV + 20;
   logic ce_r;
   logic sck_r;
   logic cfg_r;
   logic [7:0] addr_r;
   int gap_r;
   int idle_r;
   wire logic rst_any = srst_i || !reset_n_pin_i;
   wire logic ce_fall = ce_r && !chip_enable_i;
   wire logic [6:0] outs = {scan_drive_lines_o, shared_drive_output_pins_o, general_outputs_o};
   default clocking cb @(posedge core_clk_i);
   endclocking
   // address arrives lsb first while enable is low
   always_ff @(posedge core_clk_i)
   begin
      ce_r <= chip_enable_i;
      sck_r <= serial_shift_clock_i;
      if (serial_shift_clock_i && !sck_r && !chip_enable_i)
         addr_r <= {serial_in_i, addr_r[7:1]};
   end
   // a frame may only move the outputs shortly after enable falls
   always_ff @(posedge core_clk_i)
   begin
      if (rst_any || ce_fall)
         gap_r <= 0;
      else if (clk_en_i && gap_r < 255)
         gap_r <= gap_r + 1;
   end
   // quiet long enough that any double scan has ended
   always_ff @(posedge core_clk_i)
   begin
      if (rst_any || chip_enable_i || sense_inputs_i != '0)
         idle_r <= 0;
      else if (clk_en_i && idle_r < IDLE_LIM)
         idle_r <= idle_r + 1;
   end
   // an ignored frame may also set this, so it only guards the unset case
   always_ff @(posedge core_clk_i)
   begin
      if (rst_any)
         cfg_r <= 1'b0;
      else if (ce_fall && addr_r == DEV_ADDR)
         cfg_r <= 1'b1;
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   a_srst_clear: assert property (srst_i && clk_en_i |=> outs == '0 && !data_out_oe_o)
      else $error("outputs not cleared after sync reset");
   a_pin_reset: assert property (disable iff (srst_i)
      (!reset_n_pin_i && clk_en_i)[*5] |-> outs == '0 && !data_out_oe_o)
      else $error("outputs not low during pin reset");
   a_data_low: assert property (disable iff (srst_i) data_out_oe_o |-> !data_out_o)
      else $error("open drain value not low");
   a_out_frame: assert property (disable iff (srst_i)
      !$stable(general_outputs_o) |-> gap_r < 12)
      else $error("general output moved without a frame");
   a_idle_quiet: assert property (disable iff (srst_i) idle_r == IDLE_LIM |-> $stable(outs))
      else $error("drive lines move while idle");
   a_write_release: assert property (disable iff (srst_i)
      (chip_enable_i && clk_en_i)[*8] ##0 addr_r != READ_ADDR |-> !data_out_oe_o)
      else $error("request not released during transfer");
   a_read_clear: assert property (disable iff (srst_i)
      ce_fall && addr_r == READ_ADDR |-> ##7 !data_out_oe_o [*8])
      else $error("request not cleared after read");
   a_unconfig_idle: assert property (disable iff (srst_i)
      !cfg_r && !$past(cfg_r, 4) |-> outs == '0 && !data_out_oe_o)
      else $error("activity before first frame");
   c_request: cover property (!chip_enable_i && $rose(data_out_oe_o));
   c_read: cover property (ce_fall && addr_r == READ_ADDR);
   c_pin_reset: cover property (!reset_n_pin_i [*5]);
endmodule
bind key_matrix_scanner key_scan_props #(.OSC_DIV(OSC_DIV)) key_scan_props_inst (
   .core_clk_i(core_clk_i), .srst_i(srst_i), .clk_en_i(clk_en_i),
   .reset_n_pin_i(reset_n_pin_i), .chip_enable_i(chip_enable_i),
   .serial_shift_clock_i(serial_shift_clock_i), .serial_in_i(serial_in_i),
   .sense_inputs_i(sense_inputs_i), .scan_drive_lines_o(scan_drive_lines_o),
   .shared_drive_output_pins_o(shared_drive_output_pins_o),
   .general_outputs_o(general_outputs_o), .data_out_o(data_out_o),
   .data_out_oe_o(data_out_oe_o));
`default_nettype wire

// *** bench/ctrl_model.sv ***
`default_nettype none
module ctrl_model
   import key_scan_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic line_i,
   output logic ce_o,
   output logic sck_o,
   output logic sdi_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // serial controller
   // ----------------------------------------
   initial
   begin
      ce_o = 1'b0;
      sck_o = 1'b0;
      sdi_o = 1'b0;
   end
   // 80 ns bit; line read late in the low phase so the answer has settled
   task automatic bit_io(input logic d, output logic q);
      sdi_o = d;
      repeat (5) @(negedge core_clk_i);
      q = line_i;
      sck_o = 1'b1;
      repeat (5) @(negedge core_clk_i);
      sck_o = 1'b0;
   endtask
   // clock stands low between frames
   task automatic xfer(input logic [7:0] a, input logic [29:0] d, input int n,
                       output logic [29:0] q);
      logic b;
      q = '0;
      for (int i = 0; i < 8; i++)
         bit_io(a[i], b);
      ce_o = 1'b1;
      repeat (5) @(negedge core_clk_i);
      for (int i = 0; i < n; i++)
      begin
         bit_io(d[i], b);
         q[i] = b; // a released line reads one
      end
      ce_o = 1'b0;
      sdi_o = ~sdi_o;
      repeat (5) @(negedge core_clk_i);
   endtask
endmodule
`default_nettype wire

// *** bench/key_matrix_scanner_tb.sv ***
`default_nettype none
module key_matrix_scanner_tb
   import key_scan_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   // ----------------------------------------
   // harness
   // ----------------------------------------
   localparam int D = 2;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic rst_n = 1'b1;
   logic ce, sck, sdi, oe, dout, gpo, line;
   logic stb = 1'b0;
   logic [4:0] sense;
   logic [2:0] drv_lo, drv_hi;
   logic [29:0] keys = '0;
   logic [29:0] smp;
   logic [29:0] exp_q[$];
   string name_q[$];
   int fail_count = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [31:0] rs = 32'hb014;
   assign line = oe ? 1'b0 : 1'b1;
   // drive pins in row order, drive 1 first
   wire logic [5:0] drv = {drv_hi, drv_lo};
   // ideal diode matrix: a row only feeds sense while it is driven high
   always_comb
   begin
      sense = '0;
      for (int r = 0; r < 6; r++)
         if (drv[r])
            sense |= keys[5*r +: 5];
   end
   key_matrix_scanner #(.OSC_DIV(D)) key_matrix_scanner_inst (
      .core_clk_i(clk), .srst_i(srst), .clk_en_i(1'b1), .reset_n_pin_i(rst_n),
      .chip_enable_i(ce), .serial_shift_clock_i(sck), .serial_in_i(sdi),
      .sense_inputs_i(sense), .scan_drive_lines_o(drv_lo),
      .shared_drive_output_pins_o(drv_hi), .general_outputs_o(gpo),
      .data_out_o(dout), .data_out_oe_o(oe));
   ctrl_model ctrl_model_inst (.core_clk_i(clk), .line_i(line), .ce_o(ce), .sck_o(sck),
      .sdi_o(sdi));
   initial
   begin
      forever #4 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   // expected pins {out2/6, out3/5, out4/4, drive 3..1, out1}
   function automatic logic [29:0] pins(input logic [5:0] lv, input logic [3:0] o,
                                        input logic [1:0] kp);
      logic [2:0] hi;
      hi = lv[5:3];
      if (kp[0] | kp[1])
         hi[2] = o[1];
      if (kp[1])
         hi[1] = o[2];
      if (kp == 2'b11)
         hi[0] = o[3];
      return 30'({hi, lv[2:0], o[0]});
   endfunction
   // keys on rows that are low or used as outputs read zero
   function automatic logic [29:0] kmask(input logic [5:0] lv, input logic [1:0] kp);
      logic [5:0] r;
      r = lv & {!(kp[0] | kp[1]), !kp[1], kp != 2'b11, 3'b111};
      kmask = '0;
      for (int i = 0; i < 6; i++)
         if (r[i])
            kmask[5*i +: 5] = 5'h1f;
   endfunction
   task automatic note(input string n, input logic [29:0] e, input logic [29:0] v);
      exp_q.push_back(e);
      name_q.push_back(n);
      smp = v;
      stb = 1'b1;
      @(negedge clk);
      stb = 1'b0;
      @(negedge clk);
   endtask
   task automatic cfg(input logic [5:0] lv, input logic [3:0] o, input logic [1:0] kp);
      logic [29:0] q;
      ctrl_model_inst.xfer(DEV_ADDR, {14'h0, kp, 2'b00, o, 2'b00, lv}, 16, q);
   endtask
   // bounded wait for the request, noting any pulse on a low row
   task automatic wait_req(input logic [5:0] lv, output int n, output logic [5:0] bad);
      n = 0;
      bad = '0;
      while (line !== 1'b0 && n < 4000)
      begin
         @(negedge clk);
         bad |= drv & ~lv;
         n++;
      end
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // result watcher takes the oldest note
   always @(posedge clk)
   begin
      cyc++;
      if (stb)
      begin
         checks_done++;
         if (smp !== exp_q[0])
         begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name_q[0], exp_q[0], smp);
         end
         void'(exp_q.pop_front());
         void'(name_q.pop_front());
      end
      if (cyc == 60000)
      begin
         fail_count++;
         give_verdict();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial
   begin
      logic [29:0] q;
      logic [5:0] lv, bad;
      logic [3:0] o;
      logic [1:0] kp;
      int n;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      note("reset_pins", '0, 30'({oe, drv_hi, drv_lo, gpo}));
      for (int k = 0; k < 4; k++)
      begin
         rs = xs(rs);
         lv = rs[5:0];
         o = rs[9:6];
         kp = 2'(k);
         cfg(lv, o, kp);
         note("pins", pins(lv, o, kp), 30'({drv_hi, drv_lo, gpo}));
      end
      ctrl_model_inst.xfer(DEV_ADDR ^ 8'h10, 30'h3fff, 16, q);
      note("foreign", pins(lv, o, kp), 30'({drv_hi, drv_lo, gpo}));
      for (int k = 0; k < 3; k++)
      begin
         rs = xs(rs);
         lv = rs[5:0] | 6'h01;
         kp = rs[7:6];
         cfg(lv, 4'h0, kp);
         rs = xs(rs);
         keys = rs[29:0] | 30'h1;
         wait_req(lv, n, bad);
         note("req_time", 30'h1, 30'(n >= 615*D && n <= 615*D+16));
         note("low_rows", '0, 30'(bad));
         ctrl_model_inst.xfer(READ_ADDR, '0, 30, q);
         note("keys", keys & kmask(lv, kp), q);
         wait_req(lv, n, bad);
         note("rescan", 30'h1, 30'(n >= 615*D-10 && n <= 615*D+16));
         ctrl_model_inst.xfer(READ_ADDR, '0, 30, q);
         note("keys2", keys & kmask(lv, kp), q);
         keys = '0;
         repeat (720*D) @(negedge clk);
      end
      keys = 30'h1;
      repeat (200*D) @(negedge clk);
      keys = '0;
      repeat (1000*D) @(negedge clk);
      note("short", 30'h1, 30'(line));
      // change between the two row 1 samples so the pair disagrees
      keys = 30'h1;
      repeat (150*D) @(negedge clk);
      keys = 30'h2;
      wait_req(lv, n, bad);
      ctrl_model_inst.xfer(READ_ADDR, '0, 30, q);
      note("agree", 30'h2, q);
      note("few_keys", '0, 30'($countones(q) >= 3));
      wait_req(lv, n, bad);
      rst_n = 1'b0;
      repeat (5) @(negedge clk);
      note("pin_reset", '0, 30'({oe, drv_hi, drv_lo, gpo}));
      ctrl_model_inst.xfer(READ_ADDR, '0, 30, q);
      note("reset_read", 30'h3fff_ffff, q);
      rst_n = 1'b1;
      repeat (800*D) @(negedge clk);
      note("no_frame", 30'h80, 30'({line, drv_hi, drv_lo, gpo}));
      keys = '0;
      give_verdict();
   end
endmodule
`default_nettype wire
